// [common/ccl_pkg.sv]
// Shared constants and types for the charger current control logic
package ccl_pkg;

   // Management bus slave address (7-bit form of the 8-bit value 0x12)
   localparam logic [6:0] SMB_ADDR7 = 7'h09;

   // Command codes
   localparam logic [7:0] CMD_MODE = 8'h12;
   localparam logic [7:0] CMD_ICHG = 8'h14;
   localparam logic [7:0] CMD_VCHG = 8'h15;
   localparam logic [7:0] CMD_STATUS = 8'h16;
   localparam logic [7:0] CMD_IIN = 8'h3f;

   // Reset values
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [15:0] ICHG_RST = 16'h0000;
   localparam logic [15:0] VCHG_RST = 16'h0000;
   localparam logic [15:0] IIN_RST = 16'h0000;

   // Field positions
   localparam int MON_SEL_BIT = 3;
   localparam int DEP_LSB = 9;
   localparam int DEP_MSB = 11;
   localparam int CUR_LSB = 7;
   localparam int CUR_MSB = 13;
   localparam int CUR_OVR_LSB = 14;
   localparam int CUR_OVR_MSB = 15;

   // Timing
   localparam int CLK_FREQ_KHZ = 125000;
   localparam int STEP_TIME_MS = 1;
   localparam int DEGLITCH_TIME_MS = 1000;
   localparam int STEP_CYCLES = CLK_FREQ_KHZ * STEP_TIME_MS;
   localparam int DEGLITCH_CYCLES = CLK_FREQ_KHZ * DEGLITCH_TIME_MS;
   localparam logic [3:0] RAMP_STEPS = 4'h8;

   // Regulation voltage windows and per-cell thresholds, in mV
   localparam logic [15:0] V_2CELL_MV = 16'h2328;
   localparam logic [15:0] V_3CELL_MIN_MV = 16'h2ee0;
   localparam logic [15:0] V_3CELL_MAX_MV = 16'h3840;
   localparam logic [15:0] V_4CELL_MIN_MV = 16'h3e80;
   localparam logic [15:0] V_4CELL_MAX_MV = 16'h4b00;
   localparam logic [15:0] DEP_BASE_MV = 16'h0898;
   localparam logic [15:0] DEP_STEP_MV = 16'h0064;
   localparam logic [15:0] SHORT_FALL_MV = 16'h06a4;
   localparam logic [15:0] SHORT_RISE_MV = 16'h076c;

   // Analog comparator results
   typedef struct packed {
      logic vcc_low;
      logic sleep;
      logic bat_uvt;
      logic overcurrent;
      logic bat_low_2v;
      logic temp_hot;
      logic temp_cool;
      logic therm_window;
      logic below_short;
      logic above_short;
   } ccl_sense_t;

   // Readable state of the block
   typedef struct packed {
      logic short_state;
      logic thermal_off;
      logic volt_bad;
      logic therm_ok;
      logic charge_en;
   } ccl_status_t;

   typedef enum logic [2:0] {
      SMB_IDLE = 3'h0,
      SMB_ADDR = 3'h1,
      SMB_CMD = 3'h3,
      SMB_ACK = 3'h2,
      SMB_WDATA = 3'h6,
      SMB_RDATA = 3'h7,
      SMB_RACK = 3'h5,
      SMB_IGNORE = 3'h4
   } ccl_smb_state_t;

endpackage

// [design/ccl_deglitch.sv]
// Deglitch timer: fires once a condition has held for a full interval
module ccl_deglitch
   import ccl_pkg::*;
#(
   parameter int CYCLES = DEGLITCH_CYCLES
)
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic cond_i,
   output logic fire_o
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_reg;

   // Any lapse of the condition restarts the interval
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_reg <= '0;
         fire_o <= 1'b0;
      end
      else if (ce_i)
      begin
         fire_o <= 1'b0;
         if (!cond_i)
            cnt_reg <= '0;
         else if (cnt_reg == LAST)
         begin
            cnt_reg <= '0;
            fire_o <= 1'b1;
         end
         else
            cnt_reg <= cnt_reg + 1'b1;
      end
   end

endmodule

// [design/ccl_charge_ctrl.sv]
// Charger current control: bus slave, settings decode, ramp, protection
// Notes on behaviour
// - Ramp reference in eight 1 ms steps
// - Ramp restarts whenever charging becomes enabled
// - Fault, suspend, sleep, lockout stop high side
// - Mode bit 3 selects monitored current amplifier
// - High side off above twice programmed current
// - Falling below 2 V pulses duty reset, both switches off one cycle
// - Thermal stop above 145, resume below 130
// - Cell count from regulation voltage scales thresholds
// - Bits 9-11 pick depleted threshold, 100 mV steps
// - Short below 1.7 V/cell, exit above 1.9
// - One second deglitch; shorted charges at C/8
// - Charge only inside thermistor window, else suspend
// - Temperature suspend turns off both switches
// - Bus slave at 0x12, no checksum byte
// - Only mode, current, voltage, input current and status commands
// - Charge current register, bits 7-13 weighted
// - Above 16.256 A stays enabled, clamps target
// - Zero charge current disables the charger
// - Input limit taken from input current register
// - 12 V to below 14.4 V three cells, 16 V and up four
// - 9 V setting counts as two cells
module ccl_charge_ctrl
   import ccl_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYCLES,
   parameter int DGL_CYC = DEGLITCH_CYCLES
)
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic smb_clk_i,
   input wire logic smb_data_i,
   output logic smb_data_o,
   output logic smb_data_oe_o,
   input wire ccl_sense_t sense_i,
   output logic hs_gate_o,
   output logic ls_gate_o,
   output logic duty_reset_o,
   output logic [9:0] charge_ref_o,
   output logic [6:0] input_limit_o,
   output logic monitor_sel_o,
   output logic [15:0] charge_voltage_o,
   output logic [2:0] cell_count_o,
   output logic [15:0] depleted_threshold_o,
   output logic [15:0] short_enter_threshold_o,
   output logic [15:0] short_exit_threshold_o,
   output ccl_status_t status_o,
   output logic [3:0] ramp_step_o
);

   localparam int TW = $clog2(STEP_CYC + 1);
   localparam logic [TW-1:0] STEP_LAST = TW'(STEP_CYC - 1);

   function automatic logic [2:0] cell_count(input logic [15:0] mv);
      logic [2:0] n;
      n = 3'h0;
      if (mv == V_2CELL_MV)
         n = 3'h2;
      else if (mv >= V_3CELL_MIN_MV && mv < V_3CELL_MAX_MV)
         n = 3'h3;
      else if (mv >= V_4CELL_MIN_MV)
         n = 3'h4;
      return n;
   endfunction

   function automatic logic [6:0] cur_code(input logic [15:0] r);
      logic [6:0] c;
      c = r[CUR_MSB:CUR_LSB];
      if (|r[CUR_OVR_MSB:CUR_OVR_LSB])
         c = 7'h7f;
      return c;
   endfunction

   // Synchronisers
   logic [1:0] scl_ff;
   logic [1:0] sda_ff;
   logic scl_prev;
   logic sda_prev;
   ccl_sense_t sense_meta;
   ccl_sense_t sense;

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         scl_ff <= 2'h3;
         sda_ff <= 2'h3;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
         sense_meta <= '0;
         sense <= '0;
      end
      else if (ce_i)
      begin
         scl_ff <= {scl_ff[0], smb_clk_i};
         sda_ff <= {sda_ff[0], smb_data_i};
         scl_prev <= scl_ff[1];
         sda_prev <= sda_ff[1];
         sense_meta <= sense_i;
         sense <= sense_meta;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   assign scl_rise = scl_ff[1] & ~scl_prev;
   assign scl_fall = ~scl_ff[1] & scl_prev;
   assign start_det = scl_ff[1] & scl_prev & sda_prev & ~sda_ff[1];
   assign stop_det = scl_ff[1] & scl_prev & ~sda_prev & sda_ff[1];

   // Management bus slave
   ccl_smb_state_t st_reg;
   ccl_smb_state_t after_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] cmd_reg;
   logic [7:0] lo_buf_reg;
   logic [7:0] tx_reg;
   logic [7:0] tx_hi_reg;
   logic byte_no_reg;
   logic mack_reg;
   logic [15:0] mode_reg;
   logic [15:0] ichg_reg;
   logic [15:0] vchg_reg;
   logic [15:0] iin_reg;
   logic [15:0] rd_word;
   logic wr_now;
   ccl_status_t status;

   always_comb
   begin
      case (cmd_reg)
         CMD_MODE: rd_word = mode_reg;
         CMD_ICHG: rd_word = ichg_reg;
         CMD_VCHG: rd_word = vchg_reg;
         CMD_IIN: rd_word = iin_reg;
         CMD_STATUS: rd_word = {11'h000, status};
         default: rd_word = 16'h0000;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_reg <= SMB_IDLE;
         after_reg <= SMB_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         cmd_reg <= 8'h00;
         lo_buf_reg <= 8'h00;
         tx_reg <= 8'h00;
         tx_hi_reg <= 8'h00;
         byte_no_reg <= 1'b0;
         mack_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         if (start_det)
         begin
            st_reg <= SMB_ADDR;
            bit_cnt_reg <= 4'h0;
         end
         else if (stop_det)
            st_reg <= SMB_IDLE;
         else if (scl_rise)
         begin
            case (st_reg)
               SMB_ADDR, SMB_CMD, SMB_WDATA:
               begin
                  shift_reg <= {shift_reg[6:0], sda_ff[1]};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
               SMB_RDATA: bit_cnt_reg <= bit_cnt_reg + 4'h1;
               SMB_RACK: mack_reg <= ~sda_ff[1];
               default: ;
            endcase
         end
         else if (scl_fall)
         begin
            case (st_reg)
               SMB_ADDR:
                  if (bit_cnt_reg == 4'h8)
                  begin
                     bit_cnt_reg <= 4'h0;
                     if (shift_reg[7:1] == SMB_ADDR7)
                     begin
                        st_reg <= SMB_ACK;
                        byte_no_reg <= 1'b0;
                        if (shift_reg[0])
                        begin
                           after_reg <= SMB_RDATA;
                           tx_reg <= rd_word[7:0];
                           tx_hi_reg <= rd_word[15:8];
                        end
                        else
                           after_reg <= SMB_CMD;
                     end
                     else
                        st_reg <= SMB_IGNORE;
                  end
               SMB_CMD:
                  if (bit_cnt_reg == 4'h8)
                  begin
                     bit_cnt_reg <= 4'h0;
                     cmd_reg <= shift_reg;
                     st_reg <= SMB_ACK;
                     after_reg <= SMB_WDATA;
                  end
               SMB_WDATA:
                  if (bit_cnt_reg == 4'h8)
                  begin
                     bit_cnt_reg <= 4'h0;
                     st_reg <= SMB_ACK;
                     // No checksum byte follows the data word
                     if (!byte_no_reg)
                     begin
                        lo_buf_reg <= shift_reg;
                        byte_no_reg <= 1'b1;
                        after_reg <= SMB_WDATA;
                     end
                     else
                        after_reg <= SMB_IGNORE;
                  end
               SMB_ACK: st_reg <= after_reg;
               SMB_RDATA:
                  if (bit_cnt_reg == 4'h8)
                  begin
                     bit_cnt_reg <= 4'h0;
                     st_reg <= SMB_RACK;
                  end
                  else
                     tx_reg <= {tx_reg[6:0], 1'b0};
               SMB_RACK:
                  if (mack_reg && !byte_no_reg)
                  begin
                     tx_reg <= tx_hi_reg;
                     byte_no_reg <= 1'b1;
                     st_reg <= SMB_RDATA;
                  end
                  else
                     st_reg <= SMB_IGNORE;
               default: ;
            endcase
         end
      end
   end

   assign smb_data_o = 1'b0;
   assign smb_data_oe_o = (st_reg == SMB_ACK) |
                          ((st_reg == SMB_RDATA) & ~tx_reg[7]);

   assign wr_now = scl_fall & ~start_det & ~stop_det &
                   (st_reg == SMB_WDATA) & (bit_cnt_reg == 4'h8) &
                   byte_no_reg;

   // Register file; unknown and read-only commands are ignored
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mode_reg <= MODE_RST;
         ichg_reg <= ICHG_RST;
         vchg_reg <= VCHG_RST;
         iin_reg <= IIN_RST;
      end
      else if (ce_i && wr_now)
      begin
         case (cmd_reg)
            CMD_MODE: mode_reg <= {shift_reg, lo_buf_reg};
            CMD_ICHG: ichg_reg <= {shift_reg, lo_buf_reg};
            CMD_VCHG: vchg_reg <= {shift_reg, lo_buf_reg};
            CMD_IIN: iin_reg <= {shift_reg, lo_buf_reg};
            default: ;
         endcase
      end
   end

   // Settings decode
   logic [6:0] ichg_code;
   logic [2:0] cells;
   logic volt_bad;
   logic thermal_off_reg;
   logic short_state_reg;
   logic charge_en;
   logic [3:0] step_reg;
   logic [TW-1:0] step_tmr_reg;
   logic bat_low_prev_reg;
   logic duty_reset_now;
   logic [9:0] target_fine;
   logic [13:0] ramp_prod;
   logic [15:0] dep_cell_mv;
   logic short_cond;
   logic short_fire;

   assign ichg_code = cur_code(ichg_reg);
   assign cells = cell_count(vchg_reg);
   assign volt_bad = (cells == 3'h0);
   assign charge_en = (ichg_code != 7'h00) & ~volt_bad &
                      sense.therm_window & ~thermal_off_reg &
                      ~sense.vcc_low & ~sense.sleep;

   assign status.short_state = short_state_reg;
   assign status.thermal_off = thermal_off_reg;
   assign status.volt_bad = volt_bad;
   assign status.therm_ok = sense.therm_window;
   assign status.charge_en = charge_en;

   // Thermal shutdown with hysteresis
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         thermal_off_reg <= 1'b0;
      else if (ce_i)
      begin
         if (sense.temp_hot)
            thermal_off_reg <= 1'b1;
         else if (sense.temp_cool)
            thermal_off_reg <= 1'b0;
      end
   end

   // Soft-start sequencer
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         step_reg <= 4'h0;
         step_tmr_reg <= '0;
      end
      else if (ce_i)
      begin
         if (!charge_en)
         begin
            step_reg <= 4'h0;
            step_tmr_reg <= '0;
         end
         else if (step_reg == 4'h0)
            step_reg <= 4'h1;
         else if (step_reg < RAMP_STEPS)
         begin
            if (step_tmr_reg == STEP_LAST)
            begin
               step_tmr_reg <= '0;
               step_reg <= step_reg + 4'h1;
            end
            else
               step_tmr_reg <= step_tmr_reg + 1'b1;
         end
      end
   end

   // Battery short detection with deglitch
   assign short_cond = short_state_reg ? sense.above_short :
                       sense.below_short;

   ccl_deglitch #(
      .CYCLES(DGL_CYC)
   ) u_short_dgl (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .cond_i(short_cond),
      .fire_o(short_fire)
   );

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         short_state_reg <= 1'b0;
      else if (ce_i && short_fire)
         short_state_reg <= ~short_state_reg;
   end

   // Reference in 16 mA units, one eighth of programmed current while shorted
   assign target_fine = short_state_reg ? {3'h0, ichg_code} :
                        {ichg_code, 3'h0};
   assign ramp_prod = 14'(target_fine) * 14'(step_reg);
   assign duty_reset_now = sense.bat_low_2v & ~bat_low_prev_reg;
   assign dep_cell_mv = DEP_BASE_MV +
                        16'(DEP_STEP_MV * 16'(mode_reg[DEP_MSB:DEP_LSB]));

   // Switch drive and registered outputs
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         bat_low_prev_reg <= 1'b0;
         hs_gate_o <= 1'b0;
         ls_gate_o <= 1'b0;
         duty_reset_o <= 1'b0;
         charge_ref_o <= 10'h000;
         input_limit_o <= 7'h00;
         monitor_sel_o <= 1'b0;
         charge_voltage_o <= 16'h0000;
         cell_count_o <= 3'h0;
         depleted_threshold_o <= 16'h0000;
         short_enter_threshold_o <= 16'h0000;
         short_exit_threshold_o <= 16'h0000;
         status_o <= '0;
         ramp_step_o <= 4'h0;
      end
      else if (ce_i)
      begin
         bat_low_prev_reg <= sense.bat_low_2v;
         hs_gate_o <= charge_en & (step_reg != 4'h0) &
                      ~sense.overcurrent & ~sense.bat_uvt &
                      ~duty_reset_now;
         ls_gate_o <= charge_en & (step_reg != 4'h0) &
                      ~duty_reset_now;
         duty_reset_o <= duty_reset_now;
         charge_ref_o <= charge_en ? ramp_prod[12:3] : 10'h000;
         input_limit_o <= cur_code(iin_reg);
         monitor_sel_o <= mode_reg[MON_SEL_BIT];
         charge_voltage_o <= vchg_reg;
         cell_count_o <= cells;
         depleted_threshold_o <= 16'(dep_cell_mv * 16'(cells));
         short_enter_threshold_o <= 16'(SHORT_FALL_MV * 16'(cells));
         short_exit_threshold_o <= 16'(SHORT_RISE_MV * 16'(cells));
         status_o <= status;
         ramp_step_o <= step_reg;
      end
   end

endmodule

// [test/ccl_charge_properties.sv]
// Port-level checks on the charger current control block
module ccl_props
   import ccl_pkg::*;
#(
   parameter int STEP_CYC = 8,
   parameter int DGL_CYC = 16
)
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire ccl_sense_t sense_i,
   input wire logic hs_gate_o,
   input wire logic ls_gate_o,
   input wire logic duty_reset_o,
   input wire logic [9:0] charge_ref_o,
   input wire ccl_status_t status_o,
   input wire logic [3:0] ramp_step_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int dwell;
   int lo_run;
   int hi_run;
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Length of the step run that ended on the previous edge
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
      if (!rst_n_i)
         dwell <= 0;
      else
         dwell <= $changed(ramp_step_o) ? 1 : dwell + 1;
   // Raw run lengths of the short comparators
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         lo_run <= 0;
         hi_run <= 0;
      end
      else
      begin
         lo_run <= sense_i.below_short ? lo_run + 1 : 0;
         hi_run <= sense_i.above_short ? hi_run + 1 : 0;
      end
   sequence s_no_cool;
      (!sense_i.temp_cool) [*4];
   endsequence
   sequence s_supply_lost;
      (sense_i.vcc_low || sense_i.sleep || sense_i.bat_uvt) [*6];
   endsequence
   chk_supply_hs_off: assert property (
      s_supply_lost |-> !hs_gate_o) else $error("high side on, no supply");
   chk_ovc_hs_off: assert property (
      sense_i.overcurrent [*6] |-> !hs_gate_o) else $error("high side on");
   chk_ts_both_off: assert property (
      (!sense_i.therm_window) [*6] |-> !hs_gate_o && !ls_gate_o)
      else $error("switch on outside window");
   chk_hot_stops: assert property (
      sense_i.temp_hot [*6] |-> status_o.thermal_off && !ls_gate_o)
      else $error("no thermal stop");
   chk_thermal_hold: assert property (
      s_no_cool ##0 status_o.thermal_off |=> status_o.thermal_off)
      else $error("thermal stop left early");
   chk_ramp_start: assert property (
      $rose(status_o.charge_en) |-> ##[0:2] ramp_step_o == 4'h1)
      else $error("ramp not started at step one");
   chk_ramp_abort: assert property (
      (!status_o.charge_en) [*3] |-> ramp_step_o == 4'h0 &&
      charge_ref_o == 10'h0) else $error("ramp kept while disabled");
   chk_step_dwell: assert property (
      $changed(ramp_step_o) && ramp_step_o > 4'h1 |-> dwell == STEP_CYC &&
      $past(ramp_step_o) == ramp_step_o - 4'h1) else $error("step length");
   chk_duty_rise: assert property (
      $rose(sense_i.bat_low_2v) |-> ##[2:4] duty_reset_o)
      else $error("no duty reset");
   chk_duty_gates: assert property (
      duty_reset_o |-> ##[0:1] (!hs_gate_o && !ls_gate_o))
      else $error("switches on at duty reset");
   chk_short_enter: assert property (
      $rose(status_o.short_state) |-> lo_run >= DGL_CYC &&
      lo_run <= DGL_CYC + 5) else $error("short entry timing");
   chk_short_exit: assert property (
      $fell(status_o.short_state) |-> hi_run >= DGL_CYC &&
      hi_run <= DGL_CYC + 5) else $error("short exit timing");
endmodule

bind ccl_charge_ctrl ccl_props #(.STEP_CYC(STEP_CYC), .DGL_CYC(DGL_CYC))
   u_props (.*);

// [test/ccl_host_model.sv]
// Host controller model driving the two-wire management bus
module ccl_host_model
   import ccl_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      scl_o = 1'b1;
      oe_o = 1'b0;
   end
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   // One 80 ns bus clock; data moves only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      idle(2);
      oe_o = ~b;
      idle(3);
      scl_o = 1'b1;
      idle(4);
      r = sda_i;
      idle(1);
      scl_o = 1'b0;
   endtask
   // Start (b low) or stop (b high); the clock stays high after a stop
   task automatic cond(input logic b);
      idle(2);
      oe_o = b;
      idle(3);
      scl_o = 1'b1;
      idle(5);
      oe_o = ~b;
      idle(5);
      scl_o = b;
   endtask
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
   // Word write, low byte first; no checksum byte follows
   task automatic wr_word(input logic [7:0] c, input logic [15:0] d,
      output logic [3:0] ack);
      cond(1'b0);
      put_byte({SMB_ADDR7, 1'b0}, ack[3]);
      put_byte(c, ack[2]);
      put_byte(d[7:0], ack[1]);
      put_byte(d[15:8], ack[0]);
      cond(1'b1);
   endtask
   // Word read through a repeated start; last byte is not acknowledged
   task automatic rd_word(input logic [7:0] c, output logic [15:0] d);
      logic a;
      cond(1'b0);
      put_byte({SMB_ADDR7, 1'b0}, a);
      put_byte(c, a);
      cond(1'b0);
      put_byte({SMB_ADDR7, 1'b1}, a);
      get_byte(1'b0, d[7:0]);
      get_byte(1'b1, d[15:8]);
      cond(1'b1);
   endtask
endmodule

// [test/test_ccl_charge_ctrl.sv]
// Self-checking bench for the charger current control block
module test_ccl_charge_ctrl
   import ccl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STEP = 8;
   localparam int DGL = 16;
   logic clk;
   logic rst_n;
   logic scl;
   logic host_oe;
   logic dut_oe;
   wire sda;
   ccl_sense_t sense;
   ccl_status_t status;
   logic hs;
   logic ls;
   logic [9:0] cref;
   logic [6:0] in_lim;
   logic mon_sel;
   logic [2:0] cells;
   logic [15:0] dep_thr;
   logic [15:0] sh_in;
   logic [15:0] sh_out;
   logic [15:0] vout;
   logic [3:0] step;
   logic [15:0] rd;
   logic [15:0] e;
   logic a;
   int num_errors = 0;
   int cmp_count = 0;
   logic [15:0] vt [6] = '{V_2CELL_MV, V_3CELL_MAX_MV, 16'h3a98,
      V_4CELL_MIN_MV, V_4CELL_MAX_MV, V_3CELL_MIN_MV};
   logic [15:0] ct [6] = '{16'h2, 16'h0, 16'h0, 16'h4, 16'h4, 16'h3};
   // Pulled-up data line: low while either party pulls it
   assign sda = ~(host_oe | dut_oe);
   ccl_charge_ctrl #(.STEP_CYC(STEP), .DGL_CYC(DGL)) u_dut (
      .sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .smb_clk_i(scl),
      .smb_data_i(sda), .smb_data_o(), .smb_data_oe_o(dut_oe),
      .sense_i(sense), .hs_gate_o(hs), .ls_gate_o(ls), .duty_reset_o(),
      .charge_ref_o(cref), .input_limit_o(in_lim), .monitor_sel_o(mon_sel),
      .charge_voltage_o(vout), .cell_count_o(cells),
      .depleted_threshold_o(dep_thr), .short_enter_threshold_o(sh_in),
      .short_exit_threshold_o(sh_out), .status_o(status),
      .ramp_step_o(step));
   ccl_host_model u_host (.sys_clk_i(clk), .sda_i(sda), .scl_o(scl),
      .oe_o(host_oe));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_step(input logic [3:0] s);
      int n;
      n = 0;
      while (step !== s && n < 500)
      begin
         @(negedge clk);
         n++;
      end
      if (step !== s)
      begin
         num_errors++;
         tally_and_finish();
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      logic [3:0] k;
      u_host.wr_word(c, d, k);
      chk("acks", 16'hf, 16'(k));
   endtask
   initial
   begin
      rst_n = 1'b0;
      sense = '0;
      sense.therm_window = 1'b1;
      sense.temp_cool = 1'b1;
      sense.above_short = 1'b1;
      cyc(20);
      rst_n = 1'b1;
      cyc(4);
      chk("mon_sel", 16'h0, 16'(mon_sel));
      chk("charge_en", 16'h0, 16'(status.charge_en));
      for (int i = 0; i < 6; i++)
      begin
         wr(CMD_VCHG, vt[i]);
         cyc(3);
         chk("cells", ct[i], 16'(cells));
         chk("vor", 16'(ct[i] == 16'h0), 16'(status.volt_bad));
         chk("vchg", vt[i], vout);
         chk("short_in", 16'(SHORT_FALL_MV * ct[i]), sh_in);
         chk("short_out", 16'(SHORT_RISE_MV * ct[i]), sh_out);
      end
      for (int k = 0; k < 8; k++)
      begin
         wr(CMD_MODE, {4'h0, 3'(k), 9'h008});
         cyc(3);
         e = 16'((DEP_BASE_MV + DEP_STEP_MV * k) * 3);
         chk("dep_thr", e, dep_thr);
      end
      chk("mon_sel", 16'h1, 16'(mon_sel));
      sense.therm_window = 1'b0;
      wr(CMD_ICHG, 16'h047f);
      cyc(4);
      chk("hs_gate", 16'h0, 16'(hs));
      chk("therm_ok", 16'h0, 16'(status.therm_ok));
      u_host.rd_word(CMD_ICHG, rd);
      chk("ichg_rd", 16'h047f, rd);
      sense.therm_window = 1'b1;
      for (int s = 1; s < 9; s++)
      begin
         wait_step(4'(s));
         cyc(2);
         chk("ramp_ref", 16'(8 * s), 16'(cref));
      end
      sense.overcurrent = 1'b1;
      cyc(6);
      chk("hs_gate", 16'h0, 16'(hs));
      sense.overcurrent = 1'b0;
      cyc(6);
      chk("hs_gate", 16'h1, 16'(hs));
      sense.bat_uvt = 1'b1;
      cyc(6);
      chk("hs_gate", 16'h0, 16'(hs));
      sense.bat_uvt = 1'b0;
      sense.bat_low_2v = 1'b1;
      cyc(8);
      chk("ls_gate", 16'h1, 16'(ls));
      sense.bat_low_2v = 1'b0;
      sense.temp_hot = 1'b1;
      sense.temp_cool = 1'b0;
      cyc(6);
      sense.temp_hot = 1'b0;
      cyc(10);
      chk("thermal", 16'h1, 16'(status.thermal_off));
      sense.temp_cool = 1'b1;
      wait_step(4'h3);
      sense.therm_window = 1'b0;
      cyc(6);
      chk("ramp_step", 16'h0, 16'(step));
      sense.therm_window = 1'b1;
      wait_step(4'h1);
      cyc(2);
      chk("ramp_ref", 16'h8, 16'(cref));
      sense.vcc_low = 1'b1;
      cyc(6);
      chk("hs_gate", 16'h0, 16'(hs));
      sense.vcc_low = 1'b0;
      sense.sleep = 1'b1;
      cyc(6);
      chk("hs_gate", 16'h0, 16'(hs));
      sense.sleep = 1'b0;
      wr(CMD_ICHG, 16'hc000);
      wait_step(4'h8);
      cyc(2);
      chk("ramp_ref", 16'h3f8, 16'(cref));
      sense.below_short = 1'b1;
      sense.above_short = 1'b0;
      cyc(DGL - 3);
      sense.below_short = 1'b0;
      cyc(2);
      sense.below_short = 1'b1;
      cyc(DGL - 2);
      chk("short", 16'h0, 16'(status.short_state));
      cyc(10);
      chk("short", 16'h1, 16'(status.short_state));
      chk("ramp_ref", 16'h7f, 16'(cref));
      sense.below_short = 1'b0;
      sense.above_short = 1'b1;
      cyc(DGL + 8);
      chk("ramp_ref", 16'h3f8, 16'(cref));
      wr(CMD_IIN, 16'h0200);
      cyc(3);
      chk("in_lim", 16'h4, 16'(in_lim));
      u_host.cond(1'b0);
      u_host.put_byte(8'h26, a);
      u_host.cond(1'b1);
      chk("addr_ack", 16'h0, 16'(a));
      u_host.cond(1'b0);
      u_host.put_byte({SMB_ADDR7, 1'b0}, a);
      u_host.put_byte(CMD_IIN, a);
      u_host.put_byte(8'h00, a);
      u_host.put_byte(8'h01, a);
      u_host.put_byte(8'h55, a);
      u_host.cond(1'b1);
      chk("third_ack", 16'h0, 16'(a));
      chk("in_lim", 16'h2, 16'(in_lim));
      u_host.rd_word(8'h21, rd);
      chk("unknown_rd", 16'h0, rd);
      wr(CMD_ICHG, 16'h0000);
      cyc(4);
      chk("charge_en", 16'h0, 16'(status.charge_en));
      chk("ramp_ref", 16'h0, 16'(cref));
      tally_and_finish();
   end
endmodule
